//--- verilog/relay_ao_pkg.sv
`default_nettype none

package relay_ao_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_RELAY1_SEL = 8'h00;
   localparam logic [7:0] OFS_RELAY2_SEL = 8'h04;
   localparam logic [7:0] OFS_R1_ON_DLY = 8'h08;
   localparam logic [7:0] OFS_R1_OFF_DLY = 8'h0C;
   localparam logic [7:0] OFS_R2_ON_DLY = 8'h10;
   localparam logic [7:0] OFS_R2_OFF_DLY = 8'h14;
   localparam logic [7:0] OFS_SRC_SEL = 8'h18;
   localparam logic [7:0] OFS_SRC_LO = 8'h1C;
   localparam logic [7:0] OFS_SRC_HI = 8'h20;
   localparam logic [7:0] OFS_CUR_MIN = 8'h24;
   localparam logic [7:0] OFS_CUR_MAX = 8'h28;
   localparam logic [7:0] OFS_FILTER = 8'h2C;
   localparam logic [7:0] OFS_STATUS = 8'h30;
   localparam logic [7:0] OFS_AO_VALUE = 8'h34;

   // Status register fields
   localparam int ST_RELAY_LSB = 0;
   localparam int ST_STARTED = 2;
   localparam int ST_COND_LSB = 3;

   // Relay function codes
   localparam logic [4:0] CODE_NOT_USED = 5'h00;
   localparam logic [4:0] CODE_CONV_OVERTEMP = 5'h14;
   localparam logic [4:0] CODE_CONV_OVERLOAD = 5'h15;
   localparam logic [4:0] CODE_UNDERVOLTAGE = 5'h16;
   localparam logic [4:0] CODE_AI_FIRST_LOSS = 5'h17;
   localparam logic [4:0] CODE_AI_SECOND_LOSS = 5'h18;
   localparam logic [4:0] CODE_MOTOR_OVERHEAT = 5'h19;
   localparam logic [4:0] CODE_STALL = 5'h1A;
   localparam logic [4:0] CODE_UNDERLOAD = 5'h1B;
   localparam logic [4:0] CODE_PID_SLEEP = 5'h1C;
   localparam logic [4:0] CODE_PUMP_FAN = 5'h1D;
   localparam logic [4:0] CODE_AUTOCHANGE = 5'h1E;
   localparam logic [4:0] CODE_STARTED = 5'h1F;

   // Reset values
   localparam logic [4:0] RST_RELAY_SEL = 5'h00;
   localparam logic [15:0] RST_DELAY = 16'h0000;
   localparam logic [7:0] RST_SRC_SEL = 8'h01;
   localparam logic [15:0] RST_SRC_LO = 16'h0000;
   localparam logic [15:0] RST_SRC_HI = 16'hFFFF;
   localparam logic [15:0] RST_CUR_MIN = 16'h0000;
   localparam logic [15:0] RST_CUR_MAX = 16'h4E20;
   localparam logic [3:0] RST_FILTER = 4'h0;

   // Operating data words on the input bus
   localparam int OP_WORDS = 16;

   // Time base: one tick per millisecond
   localparam int CLK_PERIOD_NS = 20;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;

   // Divider iterations for the scaling quotient
   localparam logic [5:0] DIV_STEPS = 6'h20;

   typedef enum logic {DIV_IDLE, DIV_RUN} div_state_t;

endpackage

`default_nettype wire

//--- verilog/relay_ao_select.sv
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module relay_ao_select #(
   parameter int TICK_CYC = relay_ao_pkg::TICK_CYC
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Drive status conditions
   input wire logic conv_overtemp,
   input wire logic conv_overload,
   input wire logic undervoltage,
   input wire logic analog_input_first_loss,
   input wire logic analog_input_second_loss,
   input wire logic motor_overheat,
   input wire logic stall,
   input wire logic underload,
   input wire logic pid_sleep,
   input wire logic [1:0] pump_fan_staging,
   input wire logic autochange,
   input wire logic start_cmd,
   input wire logic stop_cmd,
   input wire logic fault,
   // Operating data, word n is quantity number n+1
   input wire logic [16*relay_ao_pkg::OP_WORDS-1:0] op_data,
   // Outputs
   output logic [1:0] relay_out,
   output logic [15:0] analog_current_output
);

   logic [4:0] relay_sel_q [2];
   logic [15:0] on_dly_q [2];
   logic [15:0] off_dly_q [2];
   logic [7:0] src_sel_q;
   logic [15:0] src_lo_q;
   logic [15:0] src_hi_q;
   logic [15:0] cur_min_q;
   logic [15:0] cur_max_q;
   logic [3:0] filter_q;
   logic started_q;
   logic [1:0] cond;
   logic [1:0] relay_q;
   logic [15:0] cnt_q [2];
   logic [16:0] tick_cnt_q;
   logic tick_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_d;
   logic rd_ok;
   logic wr_en;

   // Millisecond time base shared by relay delays and the filter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_cnt_q <= 17'h00000;
         tick_q <= 1'b0;
      end
      else if (tick_cnt_q == 17'(TICK_CYC - 1))
      begin
         tick_cnt_q <= 17'h00000;
         tick_q <= 1'b1;
      end
      else
      begin
         tick_cnt_q <= tick_cnt_q + 17'h00001;
         tick_q <= 1'b0;
      end
   end

   // APB: one wait state, so write and read data meet pready at the same edge
   assign wr_en = psel & penable & pwrite & pready_q;

   always_comb
   begin
      rd_d = 32'h00000000;
      rd_ok = 1'b1;
      if (paddr == relay_ao_pkg::OFS_RELAY1_SEL)
         rd_d = {27'h0000000, relay_sel_q[0]};
      else if (paddr == relay_ao_pkg::OFS_RELAY2_SEL)
         rd_d = {27'h0000000, relay_sel_q[1]};
      else if (paddr == relay_ao_pkg::OFS_R1_ON_DLY)
         rd_d = {16'h0000, on_dly_q[0]};
      else if (paddr == relay_ao_pkg::OFS_R1_OFF_DLY)
         rd_d = {16'h0000, off_dly_q[0]};
      else if (paddr == relay_ao_pkg::OFS_R2_ON_DLY)
         rd_d = {16'h0000, on_dly_q[1]};
      else if (paddr == relay_ao_pkg::OFS_R2_OFF_DLY)
         rd_d = {16'h0000, off_dly_q[1]};
      else if (paddr == relay_ao_pkg::OFS_SRC_SEL)
         rd_d = {24'h000000, src_sel_q};
      else if (paddr == relay_ao_pkg::OFS_SRC_LO)
         rd_d = {16'h0000, src_lo_q};
      else if (paddr == relay_ao_pkg::OFS_SRC_HI)
         rd_d = {16'h0000, src_hi_q};
      else if (paddr == relay_ao_pkg::OFS_CUR_MIN)
         rd_d = {16'h0000, cur_min_q};
      else if (paddr == relay_ao_pkg::OFS_CUR_MAX)
         rd_d = {16'h0000, cur_max_q};
      else if (paddr == relay_ao_pkg::OFS_FILTER)
         rd_d = {28'h0000000, filter_q};
      else if (paddr == relay_ao_pkg::OFS_STATUS)
         rd_d = {27'h0000000, cond, started_q, relay_q};
      else if (paddr == relay_ao_pkg::OFS_AO_VALUE)
         rd_d = {16'h0000, analog_current_output};
      else
         rd_ok = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end
      else
      begin
         pready_q <= psel & penable & ~pready_q;
         pslverr_q <= psel & penable & ~pready_q & ~rd_ok;
         if (psel & penable & ~pready_q & ~pwrite)
            prdata_q <= rd_d;
      end
   end

   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;

   // Configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         relay_sel_q[0] <= relay_ao_pkg::RST_RELAY_SEL;
         relay_sel_q[1] <= relay_ao_pkg::RST_RELAY_SEL;
         on_dly_q[0] <= relay_ao_pkg::RST_DELAY;
         on_dly_q[1] <= relay_ao_pkg::RST_DELAY;
         off_dly_q[0] <= relay_ao_pkg::RST_DELAY;
         off_dly_q[1] <= relay_ao_pkg::RST_DELAY;
         src_sel_q <= relay_ao_pkg::RST_SRC_SEL;
         src_lo_q <= relay_ao_pkg::RST_SRC_LO;
         src_hi_q <= relay_ao_pkg::RST_SRC_HI;
         cur_min_q <= relay_ao_pkg::RST_CUR_MIN;
         cur_max_q <= relay_ao_pkg::RST_CUR_MAX;
         filter_q <= relay_ao_pkg::RST_FILTER;
      end
      else if (wr_en)
      begin
         if (paddr == relay_ao_pkg::OFS_RELAY1_SEL)
            relay_sel_q[0] <= pwdata[4:0];
         else if (paddr == relay_ao_pkg::OFS_RELAY2_SEL)
            relay_sel_q[1] <= pwdata[4:0];
         else if (paddr == relay_ao_pkg::OFS_R1_ON_DLY)
            on_dly_q[0] <= pwdata[15:0];
         else if (paddr == relay_ao_pkg::OFS_R1_OFF_DLY)
            off_dly_q[0] <= pwdata[15:0];
         else if (paddr == relay_ao_pkg::OFS_R2_ON_DLY)
            on_dly_q[1] <= pwdata[15:0];
         else if (paddr == relay_ao_pkg::OFS_R2_OFF_DLY)
            off_dly_q[1] <= pwdata[15:0];
         else if (paddr == relay_ao_pkg::OFS_SRC_SEL)
            src_sel_q <= pwdata[7:0];
         else if (paddr == relay_ao_pkg::OFS_SRC_LO)
            src_lo_q <= pwdata[15:0];
         else if (paddr == relay_ao_pkg::OFS_SRC_HI)
            src_hi_q <= pwdata[15:0];
         else if (paddr == relay_ao_pkg::OFS_CUR_MIN)
            cur_min_q <= pwdata[15:0];
         else if (paddr == relay_ao_pkg::OFS_CUR_MAX)
            cur_max_q <= pwdata[15:0];
         else if (paddr == relay_ao_pkg::OFS_FILTER)
            filter_q <= pwdata[3:0];
      end
   end

   // Started latch: stop or fault wins over a simultaneous start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         started_q <= 1'b0;
      else if (stop_cmd | fault)
         started_q <= 1'b0;
      else if (start_cmd)
         started_q <= 1'b1;
   end

   // Condition selection, identical code set for both relays
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         case (relay_sel_q[i])
            relay_ao_pkg::CODE_CONV_OVERTEMP: cond[i] = conv_overtemp;
            relay_ao_pkg::CODE_CONV_OVERLOAD: cond[i] = conv_overload;
            relay_ao_pkg::CODE_UNDERVOLTAGE: cond[i] = undervoltage;
            relay_ao_pkg::CODE_AI_FIRST_LOSS: cond[i] = analog_input_first_loss;
            relay_ao_pkg::CODE_AI_SECOND_LOSS: cond[i] = analog_input_second_loss;
            relay_ao_pkg::CODE_MOTOR_OVERHEAT: cond[i] = motor_overheat;
            relay_ao_pkg::CODE_STALL: cond[i] = stall;
            relay_ao_pkg::CODE_UNDERLOAD: cond[i] = underload;
            relay_ao_pkg::CODE_PID_SLEEP: cond[i] = pid_sleep;
            relay_ao_pkg::CODE_PUMP_FAN: cond[i] = pump_fan_staging[i];
            relay_ao_pkg::CODE_AUTOCHANGE: cond[i] = autochange;
            relay_ao_pkg::CODE_STARTED: cond[i] = started_q;
            default: cond[i] = 1'b0;
         endcase
      end
   end

   // Delay filter: a condition change must persist for the whole delay
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         relay_q <= 2'b00;
         cnt_q[0] <= 16'h0000;
         cnt_q[1] <= 16'h0000;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (cond[i] == relay_q[i])
               cnt_q[i] <= 16'h0000;
            // Flip on the tick after the count is met: a partial first ms never shortens it
            else if (cond[i] && cnt_q[i] >= on_dly_q[i] && (tick_q || on_dly_q[i] == 16'h0000))
            begin
               relay_q[i] <= 1'b1;
               cnt_q[i] <= 16'h0000;
            end
            else if (!cond[i] && cnt_q[i] >= off_dly_q[i] && (tick_q || off_dly_q[i] == 16'h0000))
            begin
               relay_q[i] <= 1'b0;
               cnt_q[i] <= 16'h0000;
            end
            else if (tick_q && cnt_q[i] != 16'hFFFF)
               cnt_q[i] <= cnt_q[i] + 16'h0001;
         end
      end
   end

   assign relay_out = relay_q;

   // Analogue output scaling
   logic [15:0] src_val;
   logic inv;
   logic [15:0] lo;
   logic [15:0] hi;
   logic [15:0] x_clamp;
   logic [15:0] diff;
   logic [15:0] span;
   logic [15:0] den;
   logic [3:0] op_idx;

   assign op_idx = 4'(src_sel_q - 8'h01);

   always_comb
   begin
      src_val = 16'h0000;
      if (src_sel_q != 8'h00 && src_sel_q <= 8'(relay_ao_pkg::OP_WORDS))
         src_val = op_data[16*op_idx +: 16];
      inv = src_hi_q < src_lo_q;
      lo = inv ? src_hi_q : src_lo_q;
      hi = inv ? src_lo_q : src_hi_q;
      if (src_val < lo)
         x_clamp = lo;
      else if (src_val > hi)
         x_clamp = hi;
      else
         x_clamp = src_val;
      diff = inv ? hi - x_clamp : x_clamp - lo;
      span = (cur_max_q >= cur_min_q) ? cur_max_q - cur_min_q : 16'h0000;
      den = hi - lo;
   end

   // Serial divider; the quotient is refreshed every 34 cycles
   relay_ao_pkg::div_state_t div_state_q;
   logic [31:0] num_q;
   logic [16:0] rem_q;
   logic [15:0] den_q;
   logic [5:0] step_q;
   logic [15:0] target_q;
   logic [16:0] rem_sh;

   assign rem_sh = {rem_q[15:0], num_q[31]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_state_q <= relay_ao_pkg::DIV_IDLE;
         num_q <= 32'h00000000;
         rem_q <= 17'h00000;
         den_q <= 16'h0000;
         step_q <= 6'h00;
         target_q <= 16'h0000;
      end
      else
      begin
         case (div_state_q)
            relay_ao_pkg::DIV_IDLE:
            begin
               num_q <= diff * span;
               den_q <= den;
               rem_q <= 17'h00000;
               step_q <= 6'h00;
               div_state_q <= relay_ao_pkg::DIV_RUN;
            end
            default:
            begin
               if (step_q == relay_ao_pkg::DIV_STEPS)
               begin
                  // Zero content span: output sits at the minimum current
                  if (den_q == 16'h0000)
                     target_q <= cur_min_q;
                  else
                     target_q <= cur_min_q + num_q[15:0];
                  div_state_q <= relay_ao_pkg::DIV_IDLE;
               end
               else
               begin
                  if (rem_sh >= {1'b0, den_q})
                  begin
                     rem_q <= rem_sh - {1'b0, den_q};
                     num_q <= {num_q[30:0], 1'b1};
                  end
                  else
                  begin
                     rem_q <= rem_sh;
                     num_q <= {num_q[30:0], 1'b0};
                  end
                  step_q <= step_q + 6'h01;
               end
            end
         endcase
      end
   end

   // First-order filter, time constant 2^filter ms; 8 fraction bits keep small steps
   logic [23:0] y_q;
   logic signed [24:0] err;
   logic [15:0] ao_q;

   assign err = $signed({1'b0, target_q, 8'h00}) - $signed({1'b0, y_q});

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         y_q <= 24'h000000;
         ao_q <= 16'h0000;
      end
      else
      begin
         if (filter_q == 4'h0)
            y_q <= {target_q, 8'h00};
         else if (tick_q)
            y_q <= 24'($signed({1'b0, y_q}) + (err >>> filter_q));
         ao_q <= y_q[23:8];
      end
   end

   assign analog_current_output = ao_q;

   // Checks
   sequence start_alone;
      start_cmd && !stop_cmd && !fault;
   endsequence

   sequence stop_or_fault;
      stop_cmd || fault;
   endsequence

   chk_started_set: assert property (@(posedge pclk) disable iff (!presetn)
      start_alone |=> started_q)
      else $error("started latch not set by start");

   chk_started_clear: assert property (@(posedge pclk) disable iff (!presetn)
      stop_or_fault |=> !started_q)
      else $error("started latch not cleared by stop or fault");

   chk_overtemp_sel: assert property (@(posedge pclk) disable iff (!presetn)
      relay_sel_q[0] == relay_ao_pkg::CODE_CONV_OVERTEMP |-> cond[0] == conv_overtemp)
      else $error("overtemperature code selects wrong condition");

   chk_overload_sel: assert property (@(posedge pclk) disable iff (!presetn)
      relay_sel_q[1] == relay_ao_pkg::CODE_CONV_OVERLOAD |-> cond[1] == conv_overload)
      else $error("overload code selects wrong condition");

   chk_undervolt_sel: assert property (@(posedge pclk) disable iff (!presetn)
      relay_sel_q[0] == relay_ao_pkg::CODE_UNDERVOLTAGE |-> cond[0] == undervoltage)
      else $error("undervoltage code selects wrong condition");

   chk_relay_on_cause: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(relay_q[0]) |-> $past(cond[0]) && $past(cnt_q[0]) >= $past(on_dly_q[0]))
      else $error("relay energised before on delay");

   chk_relay_off_cause: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(relay_q[1]) |-> !$past(cond[1]) && $past(cnt_q[1]) >= $past(off_dly_q[1]))
      else $error("relay released before off delay");

   chk_short_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      !relay_q[0] && on_dly_q[0] != 16'h0000 && cond[0] ##1 !cond[0] |=> !relay_q[0])
      else $error("short condition pulse passed the on delay");

   chk_clamp_low: assert property (@(posedge pclk) disable iff (!presetn)
      !inv && src_val <= lo |-> diff == 16'h0000)
      else $error("content below minimum not clamped");

   chk_inverse_map: assert property (@(posedge pclk) disable iff (!presetn)
      inv && src_val >= hi |-> diff == 16'h0000)
      else $error("inverted scaling wrong at content top");

endmodule

`default_nettype wire

//--- verification/relay_load_model.sv
`timescale 1ns/1ps
`default_nettype none

module relay_load_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Device outputs
   input wire logic [1:0] relay_out,
   input wire logic [15:0] analog_current_output,
   // Observations of the load side
   output logic [7:0] first_energise_cnt,
   output logic [15:0] loop_current
);
   logic relay_last_q;

   // Counting coil pickups shows glitches that a level check would miss
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         relay_last_q <= 1'b0;
         first_energise_cnt <= 8'h00;
      end
      else
      begin
         relay_last_q <= relay_out[0];
         if (relay_out[0] && !relay_last_q)
         begin
            first_energise_cnt <= first_energise_cnt + 8'h01;
         end
      end
   end

   // Current loop receiver samples the output code every clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         loop_current <= 16'h0000;
      end
      else
      begin
         loop_current <= analog_current_output;
      end
   end
endmodule

`default_nettype wire

//--- verification/relay_ao_select_tb.sv
`timescale 1ns/1ps
`default_nettype none

module relay_ao_select_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [10:0] cnd = 11'h000;
   logic start_cmd = 1'b0;
   logic stop_cmd = 1'b0;
   logic fault = 1'b0;
   logic [255:0] op_data = 256'h0;
   logic [1:0] relay_out;
   logic [15:0] ao;
   logic [7:0] pick_cnt;
   logic [15:0] loop_cur;
   logic [31:0] rd;
   logic err;
   int num_errors = 0;
   int checks_done = 0;

   always #10 pclk = ~pclk;

   // Short tick keeps millisecond delays to tens of cycles
   relay_ao_select #(.TICK_CYC(10)) relay_ao_select_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_overtemp(cnd[0]),
      .conv_overload(cnd[1]), .undervoltage(cnd[2]),
      .analog_input_first_loss(cnd[3]), .analog_input_second_loss(cnd[4]),
      .motor_overheat(cnd[5]), .stall(cnd[6]), .underload(cnd[7]),
      .pid_sleep(cnd[8]), .pump_fan_staging({2{cnd[9]}}), .autochange(cnd[10]),
      .start_cmd(start_cmd), .stop_cmd(stop_cmd), .fault(fault),
      .op_data(op_data), .relay_out(relay_out), .analog_current_output(ao)
   );

   relay_load_model relay_load_model_inst (
      .pclk(pclk), .presetn(presetn), .relay_out(relay_out),
      .analog_current_output(ao), .first_energise_cnt(pick_cnt),
      .loop_current(loop_cur)
   );

   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // One APB transfer; bus released one edge before returning
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         num_errors++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic relay_is(input logic [1:0] exp);
      check("relay_out", {30'h0, relay_out}, {30'h0, exp});
   endtask

   initial
   begin
      idle(12);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values and an unmapped place
      apb(1'b0, relay_ao_pkg::OFS_SRC_SEL, 32'h0);
      check("src_sel", rd, 32'h1);
      apb(1'b0, relay_ao_pkg::OFS_SRC_HI, 32'h0);
      check("src_hi", rd, 32'hFFFF);
      apb(1'b0, relay_ao_pkg::OFS_CUR_MAX, 32'h0);
      check("cur_max", rd, 32'h4E20);
      apb(1'b0, 8'h80, 32'h0);
      check("unmapped_err", {31'h0, err}, 32'h1);
      // Every condition code on both relays, others must not leak in
      for (int c = 20; c <= 30; c++)
      begin
         apb(1'b1, relay_ao_pkg::OFS_RELAY1_SEL, 32'(c));
         apb(1'b1, relay_ao_pkg::OFS_RELAY2_SEL, 32'(c));
         cnd <= 11'h001 << (c - 20);
         idle(4);
         relay_is(2'b11);
         cnd <= ~(11'h001 << (c - 20));
         idle(4);
         relay_is(2'b00);
         cnd <= 11'h000;
      end
      // Started latch: start on, stop off, fault wins a tie with start
      apb(1'b1, relay_ao_pkg::OFS_RELAY1_SEL, 32'h1F);
      apb(1'b1, relay_ao_pkg::OFS_RELAY2_SEL, 32'h1F);
      start_cmd <= 1'b1;
      idle(1);
      start_cmd <= 1'b0;
      idle(4);
      relay_is(2'b11);
      stop_cmd <= 1'b1;
      idle(1);
      stop_cmd <= 1'b0;
      idle(4);
      relay_is(2'b00);
      start_cmd <= 1'b1;
      fault <= 1'b1;
      idle(1);
      start_cmd <= 1'b0;
      fault <= 1'b0;
      idle(4);
      relay_is(2'b00);
      // Delays on relay one only: 3 ms on, 2 ms off, relay two immediate
      apb(1'b1, relay_ao_pkg::OFS_RELAY1_SEL, 32'h15);
      apb(1'b1, relay_ao_pkg::OFS_RELAY2_SEL, 32'h15);
      apb(1'b1, relay_ao_pkg::OFS_R1_ON_DLY, 32'h3);
      apb(1'b1, relay_ao_pkg::OFS_R1_OFF_DLY, 32'h2);
      // Relay one picked up once per condition code and once for start so far
      check("pickups_before", {24'h0, pick_cnt}, 32'hC);
      cnd <= 11'h002;
      idle(10);
      cnd <= 11'h000;
      idle(60);
      check("short_pulse", {24'h0, pick_cnt}, 32'hC);
      cnd <= 11'h002;
      idle(25);
      relay_is(2'b10);
      idle(25);
      relay_is(2'b11);
      cnd <= 11'h000;
      idle(15);
      relay_is(2'b01);
      idle(25);
      relay_is(2'b00);
      check("pickups_after", {24'h0, pick_cnt}, 32'hD);
      // Analogue scaling, inversion and clamping with filter off
      apb(1'b1, relay_ao_pkg::OFS_SRC_HI, 32'h3E8);
      apb(1'b1, relay_ao_pkg::OFS_CUR_MAX, 32'h7D0);
      op_data[15:0] <= 16'h01F4;
      idle(120);
      check("ao_linear", {16'h0, loop_cur}, 32'h3E8);
      apb(1'b1, relay_ao_pkg::OFS_SRC_LO, 32'h3E8);
      apb(1'b1, relay_ao_pkg::OFS_SRC_HI, 32'h0);
      op_data[15:0] <= 16'h00FA;
      idle(120);
      check("ao_inverse", {16'h0, ao}, 32'h5DC);
      apb(1'b1, relay_ao_pkg::OFS_CUR_MIN, 32'h64);
      op_data[15:0] <= 16'h07D0;
      idle(120);
      check("ao_clamp", {16'h0, ao}, 32'h64);
      // Filter of 2^3 ms: target moves 34 to 68 cycles after the step, then 3 to 7 ticks
      apb(1'b1, relay_ao_pkg::OFS_FILTER, 32'h3);
      op_data[15:0] <= 16'h0000;
      idle(100);
      check("ao_filtered", {31'h0, ao < 16'h05DC && ao > 16'h0064}, 32'h1);
      test_done();
   end
endmodule

`default_nettype wire
